//--- inc/cprs_pkg.sv
// Constants and types of the codec power-on reset sequencer
package cprs_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int GLITCH_NS       = 50;
  localparam int MIN_RESET_NS    = 6000;
  localparam int NOM_RESET_NS    = 10000;
  // Glitch filter: a low must persist longer than the glitch time (round up)
  localparam int GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int MIN_RESET_CYC   = (MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOM_RESET_CYC   = (NOM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_CYC     = (NOM_RESET_CYC > MIN_RESET_CYC) ? NOM_RESET_CYC
                                                                   : MIN_RESET_CYC;
  localparam int CNT_W           = 8;
  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_CYC - 1);
  localparam logic [CNT_W-1:0] GLITCH_LAST  = CNT_W'(GLITCH_CYC - 1);
  // Configuration word
  localparam int CFG_W           = 16;
  localparam int ADDR_W          = 7;
  localparam int PIN_W           = 4;
  localparam logic [ADDR_W-1:0] SW_RESET_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] CFG_ADDR      = 7'h01;
  // Config defaults: bit 15 presets to one, rest clear
  localparam logic [CFG_W-1:0]  CFG_DEFAULT   = 16'h8000;
  localparam int CFG_ANA_MIC_BIT = 0;
  localparam int CFG_DIG_MIC_BIT = 1;
  localparam int CFG_PIN_EN_BIT  = 2;
  typedef enum logic [1:0] {CPRS_IN_RESET, CPRS_STRETCH, CPRS_STANDBY, CPRS_ACTIVE} cprs_state_t;
endpackage

//--- core/cprs_sync.sv
// Two-stage synchroniser with asynchronous preset value zero
`timescale 1ns/1ps
module cprs_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_ff;
  // Second flop alone reads the first
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= 1'b0;
      o_q     <= 1'b0;
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end
endmodule

//--- core/cprs_top.sv
// Power-on reset sequencer with default register and pin tri-state control
`timescale 1ns/1ps
module cprs_top (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  input  wire logic                       i_supply_ok,
  input  wire logic                       i_wr_en,
  input  wire logic [cprs_pkg::ADDR_W-1:0] i_wr_addr,
  input  wire logic [cprs_pkg::CFG_W-1:0]  i_wr_data,
  input  wire logic [cprs_pkg::PIN_W-1:0]  i_pin_out,
  output logic                            o_power_on_reset_low,
  output logic                            o_wr_accept,
  output logic                            o_standby,
  output logic [cprs_pkg::CFG_W-1:0]       o_cfg,
  output logic [cprs_pkg::PIN_W-1:0]       o_pin_out,
  output logic [cprs_pkg::PIN_W-1:0]       o_pin_oe_n
);
  import cprs_pkg::*;

  // ----------------------------------------------------------------
  // Supply level synchroniser
  // ----------------------------------------------------------------
  logic supply_sync;

  cprs_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_d       (i_supply_ok),
    .o_q       (supply_sync)
  );

  // ----------------------------------------------------------------
  // Glitch filter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_ff;
  logic             supply_bad_ff;

  // Supply must stay low past glitch length before it counts
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_ff    <= '0;
      supply_bad_ff <= 1'b1;
    end else if (i_ce) begin
      if (supply_sync) begin
        low_cnt_ff    <= '0;
        supply_bad_ff <= 1'b0;
      end else if (low_cnt_ff == GLITCH_LAST) begin
        supply_bad_ff <= 1'b1;
      end else begin
        low_cnt_ff    <= low_cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  cprs_state_t      state_ff;
  cprs_state_t      nxt_state;
  logic [CNT_W-1:0] wid_cnt_ff;
  logic             sw_reset;

  assign sw_reset = i_wr_en && (state_ff == CPRS_ACTIVE) && (i_wr_addr == SW_RESET_ADDR);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CPRS_IN_RESET: if (!supply_bad_ff) nxt_state = CPRS_STRETCH;
      CPRS_STRETCH:  if (supply_bad_ff) nxt_state = CPRS_IN_RESET;
                     else if (wid_cnt_ff == STRETCH_LAST) nxt_state = CPRS_STANDBY;
      CPRS_STANDBY:  if (supply_bad_ff) nxt_state = CPRS_IN_RESET;
                     else nxt_state = CPRS_ACTIVE;
      CPRS_ACTIVE:   if (supply_bad_ff) nxt_state = CPRS_IN_RESET;
      default:       nxt_state = CPRS_IN_RESET;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= CPRS_IN_RESET;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // Reset width counter, counts only in CPRS_STRETCH, once the supply is good
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wid_cnt_ff <= '0;
    end else if (i_ce) begin
      if (state_ff != CPRS_STRETCH) begin
        wid_cnt_ff <= '0;
      end else begin
        wid_cnt_ff <= wid_cnt_ff + 1'b1;
      end
    end
  end

  // Internal reset released on a clock edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_power_on_reset_low <= 1'b0;
    end else if (i_ce) begin
      o_power_on_reset_low <= (nxt_state == CPRS_STANDBY) || (nxt_state == CPRS_ACTIVE);
    end
  end

  // Write acceptance and stand-by flags
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_accept <= 1'b0;
      o_standby   <= 1'b1;
    end else if (i_ce) begin
      o_wr_accept <= (nxt_state == CPRS_ACTIVE);
      o_standby   <= (nxt_state != CPRS_ACTIVE) || sw_reset ||
                     (o_cfg[CFG_ANA_MIC_BIT] == 1'b0 && o_cfg[CFG_DIG_MIC_BIT] == 1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Defaults while in reset or on software reset write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg <= CFG_DEFAULT;
    end else if (i_ce) begin
      // Supply loss forces defaults on the same edge that drops the reset output
      if (state_ff != CPRS_ACTIVE || supply_bad_ff) begin
        o_cfg <= CFG_DEFAULT;
      end else if (sw_reset) begin
        o_cfg <= CFG_DEFAULT;
      end else if (i_wr_en && i_wr_addr == CFG_ADDR) begin
        o_cfg <= i_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital pins
  // ----------------------------------------------------------------
  // Pins float while supply is bad or pins are disabled
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out  <= '0;
      o_pin_oe_n <= '1;
    end else if (i_ce) begin
      if (supply_bad_ff || state_ff != CPRS_ACTIVE || !o_cfg[CFG_PIN_EN_BIT]) begin
        o_pin_out  <= '0;
        o_pin_oe_n <= '1;
      end else begin
        o_pin_out  <= i_pin_out;
        o_pin_oe_n <= '0;
      end
    end
  end
endmodule

//--- testbench/cprs_properties.sv
// Checker of the reset sequencer ports
`timescale 1ns/1ps
module cprs_properties import cprs_pkg::*; (
  input wire logic               i_ref_clk, i_rst, i_ce, i_supply_ok, i_wr_en,
  input wire logic [ADDR_W-1:0]  i_wr_addr,
  input wire logic [CFG_W-1:0]   i_wr_data, o_cfg,
  input wire logic [PIN_W-1:0]   i_pin_out, o_pin_out, o_pin_oe_n,
  input wire logic               o_power_on_reset_low, o_wr_accept, o_standby
);
  logic [7:0] low_ff;
  // Cycles spent in reset so far
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) low_ff <= 8'h00;
    else if (o_power_on_reset_low) low_ff <= 8'h00;
    else if (low_ff != 8'hFF) low_ff <= low_ff + 8'h01;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr(a); o_wr_accept && i_ce && i_wr_en && i_wr_addr == a; endsequence
  sequence s_blip;
    (o_wr_accept && i_supply_ok) ##1 i_supply_ok[*3] ##1 !i_supply_ok ##1 i_supply_ok[*6];
  endsequence
  property p_tri; !o_power_on_reset_low |-> o_pin_oe_n == 4'hF && o_pin_out == 4'h0; endproperty
  a_tri: assert property (p_tri) else $error("pins driven in reset");
  property p_dflt; !o_power_on_reset_low |-> o_cfg == CFG_DEFAULT && o_standby; endproperty
  a_dflt: assert property (p_dflt) else $error("cfg not default");
  property p_wr; s_wr(CFG_ADDR) |=> o_cfg == $past(i_wr_data); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_swr; s_wr(SW_RESET_ADDR) |=> o_cfg == CFG_DEFAULT && o_standby; endproperty
  a_swr: assert property (p_swr) else $error("soft reset failed");
  property p_loss; !i_supply_ok[*5] |-> ##[0:3] !o_power_on_reset_low; endproperty
  a_loss: assert property (p_loss) else $error("no reset on low supply");
  property p_blip; s_blip |-> o_power_on_reset_low; endproperty
  a_blip: assert property (p_blip) else $error("glitch caused reset");
  property p_len; $rose(o_power_on_reset_low) |-> low_ff >= 8'h62; endproperty
  a_len: assert property (p_len) else $error("reset too short");
  property p_sync; $rose(o_power_on_reset_low) |-> !o_wr_accept ##1 o_wr_accept; endproperty
  a_sync: assert property (p_sync) else $error("release out of step");
endmodule

//--- testbench/cprs_host.sv
// Host controller model driving the sequencer write port
`timescale 1ns/1ps
module cprs_host import cprs_pkg::*; #(parameter int SETTLE_CYC = 10000, AUDIO_CYC = 10000) (
  input wire logic          i_ref_clk, i_ready,
  output logic              o_wr_en, o_audio_go,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [CFG_W-1:0]  o_wr_data
);
  int up_cnt = 0;
  int idle_cnt = 0;
  initial {o_wr_en, o_wr_addr, o_wr_data} = '0;
  // Settle time after power-up and quiet time after the last write
  always @(posedge i_ref_clk) begin
    up_cnt <= i_ready ? up_cnt + 1 : 0;
    idle_cnt <= o_wr_en ? 0 : idle_cnt + 1;
  end
  assign o_audio_go = up_cnt > SETTLE_CYC && idle_cnt > AUDIO_CYC;
  // One register write; never both mic inputs on
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CFG_W-1:0] d);
    for (int n = 0; n < 90000 && up_cnt <= SETTLE_CYC; n++) @(posedge i_ref_clk);
    o_wr_en <= 1'b1;
    o_wr_addr <= a;
    o_wr_data <= d & ~(CFG_W'(d[CFG_ANA_MIC_BIT]) << CFG_DIG_MIC_BIT);
    @(posedge i_ref_clk);
  endtask
  task automatic rel();
    o_wr_en <= 1'b0;
    @(posedge i_ref_clk);
  endtask
endmodule

//--- testbench/cprs_top_bench.sv
// Testbench of the power-on reset sequencer
`timescale 1ns/1ps
module cprs_top_bench;
  import cprs_pkg::*;
  logic              clk, rst, ce, sup, wen, go, rl, acc, sby;
  logic [ADDR_W-1:0] wa, a;
  logic [CFG_W-1:0]  wd, cfg, d, exp_cfg;
  logic [PIN_W-1:0]  pin, pout, poe;
  logic [CFG_W-1:0]  q[$];
  int fail_count = 0, cmp_count = 0, seed = 96323;
  cprs_top cprs_top_i (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_supply_ok(sup),
    .i_wr_en(wen), .i_wr_addr(wa), .i_wr_data(wd), .i_pin_out(pin),
    .o_power_on_reset_low(rl), .o_wr_accept(acc), .o_standby(sby), .o_cfg(cfg),
    .o_pin_out(pout), .o_pin_oe_n(poe));
  cprs_host #(.SETTLE_CYC(20), .AUDIO_CYC(30)) cprs_host_i (.i_ref_clk(clk), .i_ready(acc),
    .o_wr_en(wen), .o_wr_addr(wa), .o_wr_data(wd), .o_audio_go(go));
  task automatic check(input string nm, input logic [CFG_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_up();
    int n;
    n = 0;
    while (acc !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) fail_count++;
    if (n == 400) finish_test();
    check("stretch", n > 99, 1'b1);
    check("default cfg", cfg, CFG_DEFAULT);
    check("standby", sby, 1'b1);
  endtask
  // Clock and pin data
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) pin <= 4'($random(seed));
  // Watcher takes the oldest note for every taken write
  always @(posedge clk) begin
    if (wen === 1'b1 && acc === 1'b1 && ce === 1'b1) begin
      @(negedge clk);
      check("cfg", cfg, q.pop_front());
    end
  end
  initial begin
    #5000000 fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst, ce, sup, pin} = {3'h7, 4'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_up();
    $display("test power_up done");
    exp_cfg = CFG_DEFAULT;
    for (int i = 0; i < 16; i++) begin
      a = (i % 5 == 4) ? SW_RESET_ADDR : (i % 7 == 6) ? 7'h05 : CFG_ADDR;
      d = 16'($random(seed));
      if (d[CFG_ANA_MIC_BIT]) d[CFG_DIG_MIC_BIT] = 1'b0;
      exp_cfg = (a == SW_RESET_ADDR) ? CFG_DEFAULT : (a == CFG_ADDR) ? d : exp_cfg;
      q.push_back(exp_cfg);
      cprs_host_i.wr(a, d);
    end
    cprs_host_i.rel();
    $display("test writes done");
    ce <= 1'b0;
    cprs_host_i.wr(CFG_ADDR, 16'h0004);
    cprs_host_i.rel();
    ce <= 1'b1;
    @(negedge clk) check("frozen cfg", cfg, exp_cfg);
    $display("test freeze done");
    repeat (40) @(posedge clk);
    check("audio start", go, 1'b1);
    $display("test audio_start done");
    sup <= 1'b0;
    @(posedge clk) sup <= 1'b1;
    repeat (8) @(posedge clk);
    check("glitch", acc, 1'b1);
    $display("test glitch done");
    sup <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk) check("reset low", rl, 1'b0);
    check("pins off", poe, 4'hF);
    check("pins data", pout, 4'h0);
    @(posedge clk) sup <= 1'b1;
    wait_up();
    $display("test supply_loss done");
    finish_test();
  end
endmodule
bind cprs_top cprs_properties cprs_properties_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_ce(i_ce), .i_supply_ok(i_supply_ok), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
  .i_wr_data(i_wr_data), .o_cfg(o_cfg), .i_pin_out(i_pin_out), .o_pin_out(o_pin_out),
  .o_pin_oe_n(o_pin_oe_n), .o_power_on_reset_low(o_power_on_reset_low),
  .o_wr_accept(o_wr_accept), .o_standby(o_standby));
